// File: rtl/hbp_pkg.sv
/*
  package of the host byte port: register offsets, field positions, reset values and
  timing counts.
  assumes a single 100 MHz clock and a plain register port with 8-bit data.
*/
package hbp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PARALLEL_DATA_PORT_OFS        = 8'h08;
  localparam logic [7:0] CONTROL_PIN_PORT_OFS          = 8'h09;
  localparam logic [7:0] PERIPHERAL_FLAG_REG_OFS       = 8'h0c;
  localparam logic [7:0] SLAVE_PORT_CONTROL_STATUS_OFS = 8'h89;
  localparam logic [7:0] PERIPHERAL_ENABLE_REG_OFS     = 8'h8c;
  localparam logic [7:0] DATA_PORT_DIRECTION_OFS       = 8'h88;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INPUT_FULL_POS    = 7;
  localparam int OUTPUT_FULL_POS   = 6;
  localparam int INPUT_OVERRUN_POS = 5;
  localparam int SLAVE_MODE_POS    = 4;
  localparam int PORT_INT_POS      = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_DIR_RESET  = 3'h7;
  localparam logic [7:0] DATA_DIR_RESET  = 8'hff;
  localparam logic [7:0] FLAG_REG_RESET  = 8'h00;
  localparam logic [7:0] EN_REG_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // timing: four clocks form one instruction cycle, phases one to four
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         CYCLE_NS       = 40;
  localparam int         PHASES         = CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [1:0] SECOND_PHASE   = 2'h1;
  localparam logic [1:0] FOURTH_PHASE   = 2'h3;

endpackage

// File: rtl/hbp_host_byte_port.sv
/*
  host byte port: 8-bit parallel slave port reached by an external bus master over
  chip select, read strobe and write strobe, and by firmware over a register port.
  assumes the register port follows the one-cycle strobe protocol with read data one
  cycle later; the strobe pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module hbp_host_byte_port (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic      [7:0] data_oe_n,
  input  wire logic [2:0] ctrl_in,
  output logic      [2:0] ctrl_out,
  output logic      [2:0] ctrl_oe_n,
  output logic            irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HBP_IDLE    = 2'b00,
    HBP_WRITE   = 2'b01,
    HBP_READ    = 2'b10,
    HBP_FINISH  = 2'b11
  } hbp_access_type;

  typedef struct packed {
    logic [2:0]     sync1;
    logic [2:0]     sync2;
    hbp_access_type acc;
    logic           was_write;
    logic           seen_second;
    logic [1:0]     phase;
    logic [7:0]     in_latch;
    logic [7:0]     out_latch;
    logic [7:0]     data_dir;
    logic [2:0]     ctrl_latch;
    logic [2:0]     ctrl_dir;
    logic           slave_mode;
    logic           input_full;
    logic           output_full;
    logic           input_overrun;
    logic [7:0]     flag_reg;
    logic [7:0]     en_reg;
    logic [7:0]     rdata;
  } hbp_state_type;

  hbp_state_type state_ff;
  hbp_state_type nxt_state;

  // synchronised pins: bit0 read strobe, bit1 write strobe, bit2 chip select
  logic rd_low;
  logic wr_low;
  logic cs_low;
  logic fw_rd_data;
  logic fw_wr_data;
  logic fw_wr_flag;

  assign rd_low = ~state_ff.sync2[0];
  assign wr_low = ~state_ff.sync2[1];
  assign cs_low = ~state_ff.sync2[2];
  assign fw_rd_data = reg_rd && (reg_addr == hbp_pkg::PARALLEL_DATA_PORT_OFS);
  assign fw_wr_data = reg_wr && (reg_addr == hbp_pkg::PARALLEL_DATA_PORT_OFS);
  assign fw_wr_flag = reg_wr && (reg_addr == hbp_pkg::PERIPHERAL_FLAG_REG_OFS);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic set_in_full;
    logic set_int;
    logic [7:0] ctrl_rd;
    set_in_full = 1'b0;
    set_int     = 1'b0;
    ctrl_rd     = 8'h00;
    nxt_state   = state_ff;

    // two-stage synchroniser; only sync2 is looked at
    nxt_state.sync1 = ctrl_in;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.phase = state_ff.phase + 2'h1;

    // host access sequencing
    case (state_ff.acc)
      HBP_IDLE: begin
        if (state_ff.slave_mode && cs_low && wr_low) begin
          nxt_state.acc = HBP_WRITE;
        end else if (state_ff.slave_mode && cs_low && rd_low) begin
          nxt_state.acc = HBP_READ;
          nxt_state.output_full = 1'b0;
        end
      end
      HBP_WRITE: begin
        nxt_state.in_latch = data_in;
        if (!cs_low || !wr_low) begin
          nxt_state.acc         = HBP_FINISH;
          nxt_state.was_write   = 1'b1;
          nxt_state.seen_second = 1'b0;
        end
      end
      HBP_READ: begin
        if (!cs_low || !rd_low) begin
          nxt_state.acc         = HBP_FINISH;
          nxt_state.was_write   = 1'b0;
          nxt_state.seen_second = 1'b0;
        end
      end
      HBP_FINISH: begin
        if (state_ff.phase == hbp_pkg::SECOND_PHASE) begin
          nxt_state.seen_second = 1'b1;
        end
        if (state_ff.seen_second && state_ff.phase == hbp_pkg::FOURTH_PHASE) begin
          nxt_state.acc = HBP_IDLE;
          set_int       = 1'b1;
          set_in_full   = state_ff.was_write;
        end
      end
      default: begin
        nxt_state.acc = HBP_IDLE;
      end
    endcase

    // firmware write side effects
    if (reg_wr) begin
      case (reg_addr)
        hbp_pkg::PARALLEL_DATA_PORT_OFS: begin
          nxt_state.out_latch = reg_wdata;
        end
        hbp_pkg::CONTROL_PIN_PORT_OFS: begin
          nxt_state.ctrl_latch = reg_wdata[2:0];
        end
        hbp_pkg::DATA_PORT_DIRECTION_OFS: begin
          nxt_state.data_dir = reg_wdata;
        end
        hbp_pkg::SLAVE_PORT_CONTROL_STATUS_OFS: begin
          nxt_state.ctrl_dir      = reg_wdata[2:0];
          nxt_state.slave_mode    = reg_wdata[hbp_pkg::SLAVE_MODE_POS];
          // overrun is firmware-writable, so only firmware clears it
          nxt_state.input_overrun = reg_wdata[hbp_pkg::INPUT_OVERRUN_POS];
        end
        hbp_pkg::PERIPHERAL_FLAG_REG_OFS: begin
          nxt_state.flag_reg = reg_wdata;
        end
        hbp_pkg::PERIPHERAL_ENABLE_REG_OFS: begin
          nxt_state.en_reg = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (fw_wr_data && state_ff.slave_mode) begin
      nxt_state.output_full = 1'b1;
    end
    if (fw_rd_data) begin
      nxt_state.input_full = 1'b0;
    end

    // hardware sets win over firmware clears
    if (set_in_full) begin
      if (state_ff.input_full && !fw_rd_data) begin
        nxt_state.input_overrun = 1'b1;
      end
      nxt_state.input_full = 1'b1;
    end
    if (set_int) begin
      nxt_state.flag_reg[hbp_pkg::PORT_INT_POS] = 1'b1;
    end

    if (!nxt_state.slave_mode) begin
      nxt_state.input_full  = 1'b0;
      nxt_state.output_full = 1'b0;
    end

    // read data, valid in the cycle after the strobe
    ctrl_rd = {5'h00, state_ff.slave_mode ? state_ff.sync2 : state_ff.sync2};
    case (reg_addr)
      hbp_pkg::PARALLEL_DATA_PORT_OFS:
        nxt_state.rdata = state_ff.slave_mode ? state_ff.in_latch : data_in;
      hbp_pkg::CONTROL_PIN_PORT_OFS:        nxt_state.rdata = ctrl_rd;
      hbp_pkg::DATA_PORT_DIRECTION_OFS:     nxt_state.rdata = state_ff.data_dir;
      hbp_pkg::SLAVE_PORT_CONTROL_STATUS_OFS:
        nxt_state.rdata = {state_ff.input_full, state_ff.output_full,
                           state_ff.input_overrun, state_ff.slave_mode,
                           1'b0, state_ff.ctrl_dir};
      hbp_pkg::PERIPHERAL_FLAG_REG_OFS:     nxt_state.rdata = state_ff.flag_reg;
      hbp_pkg::PERIPHERAL_ENABLE_REG_OFS:   nxt_state.rdata = state_ff.en_reg;
      default:                              nxt_state.rdata = 8'h00;
    endcase
    if (!reg_rd) begin
      nxt_state.rdata = 8'h00;
    end

    if (reset) begin
      nxt_state               = '0;
      nxt_state.sync1         = 3'h7;
      nxt_state.sync2         = 3'h7;
      nxt_state.acc           = HBP_IDLE;
      nxt_state.ctrl_dir      = hbp_pkg::CTRL_DIR_RESET;
      nxt_state.data_dir      = hbp_pkg::DATA_DIR_RESET;
      nxt_state.flag_reg      = hbp_pkg::FLAG_REG_RESET;
      nxt_state.en_reg        = hbp_pkg::EN_REG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state_ff.rdata;
  assign data_out  = state_ff.out_latch;
  // slave mode: drive only during a host read; direction register ignored
  assign data_oe_n = state_ff.slave_mode ? {8{state_ff.acc != HBP_READ}}
                                         : state_ff.data_dir;
  assign ctrl_out  = state_ff.ctrl_latch;
  // slave mode forces the control pins to inputs
  assign ctrl_oe_n = state_ff.slave_mode ? 3'h7 : state_ff.ctrl_dir;
  assign irq = state_ff.flag_reg[hbp_pkg::PORT_INT_POS] &
               state_ff.en_reg[hbp_pkg::PORT_INT_POS];

endmodule

// File: verification/hbp_host_byte_port_checker.sv
/* port checker of the host byte port.
   assumes one clock, synchronous active-high reset, direction reg left at reset. */
`timescale 1ns/1ps
module hbp_host_byte_port_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  input wire logic [2:0] ctrl_in,
  input wire logic [2:0] ctrl_out,
  input wire logic [2:0] ctrl_oe_n,
  input wire logic       irq
);
  logic [3:0] idle_ff;
  logic [3:0] nxt_idle;
  // cycles since a strobe or chip select pin was last low, saturating
  always_comb nxt_idle = (ctrl_in != 3'h7) ? 4'h0 : idle_ff + {3'h0, idle_ff != 4'hf};
  always_ff @(posedge clk) idle_ff <= nxt_idle;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data out of slot");
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'h08, 8'h09, 8'h0c, 8'h88, 8'h89, 8'h8c}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_bit3; reg_rd && reg_addr == 8'h89 |=> reg_rdata[3] == 1'b0; endproperty
  a_bit3: assert property (p_bit3) else $error("status bit3 set");
  property p_irq_mask; reg_wr && reg_addr == 8'h8c && !reg_wdata[7] |-> ##2 !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
  property p_irq_hold; irq && !reg_wr && !$past(reg_wr) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_irq_cause;
    $rose(irq) && !$past(reg_wr) && !$past(reg_wr, 2) |-> idle_ff <= 4'hd;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq not after access");
  property p_oe_fall;
    $fell(data_oe_n[0]) |-> !$past(ctrl_in[0], 2) && !$past(ctrl_in[2], 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive without read");
  property p_oe_rise; $rose(data_oe_n[0]) |-> $past(ctrl_in[0], 2) || $past(ctrl_in[2], 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive dropped early");
  c_irq: cover property ($rose(irq));
  c_read: cover property ($fell(data_oe_n[0]));
  c_unmapped: cover property (reg_rd && reg_addr == 8'h55);
endmodule
bind hbp_host_byte_port hbp_host_byte_port_checker i_chk (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .ctrl_in(ctrl_in), .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n), .irq(irq));

// File: verification/hbp_host_master.sv
/* model of the external bus master on the host byte port.
   assumes strobe timing: low 6 clocks, then high 10 clocks. */
`timescale 1ns/1ps
module hbp_host_master (
  input  wire logic       clk,
  output logic      [2:0] ctrl_in,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic [7:0] data_oe_n
);
  initial begin
    ctrl_in = 3'h7;
    data_in = 8'h00;
  end
  task automatic access(input logic wr, input logic [7:0] wb, output logic [7:0] rb);
    @(posedge clk);
    ctrl_in <= wr ? 3'h1 : 3'h2;
    data_in <= wr ? wb : ~data_in;
    repeat (6) @(posedge clk);
    rb = (data_oe_n === 8'h00) ? data_out : 8'hxx;
    ctrl_in <= 3'h7;
    // data held past strobe end for the synchroniser, then released
    repeat (4) @(posedge clk);
    data_in <= ~data_in;
    repeat (6) @(posedge clk);
  endtask
endmodule

// File: verification/hbp_host_byte_port_bench.sv
/* self-checking bench of the host byte port.
   assumes the master model and the bound port checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module hbp_host_byte_port_bench;
  logic       clk, reset, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, data_in, data_out, data_oe_n, rd_val, hb;
  logic [2:0] ctrl_in, ctrl_out, ctrl_oe_n;
  int         n_errors = 0;
  int         checks_done = 0;
  hbp_host_byte_port i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .ctrl_in(ctrl_in),
    .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n), .irq(irq));
  hbp_host_master i_host (.clk(clk), .ctrl_in(ctrl_in), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic ex_reg(input logic [7:0] a, e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    `CHK(rd_val, e)
  endtask
  task automatic t_reset_values();
    ex_reg(8'h89, 8'h07);
    ex_reg(8'h0c, 8'h00);
    ex_reg(8'h8c, 8'h00);
    ex_reg(8'h55, 8'h00);
    wr_reg(8'h89, 8'hc7);
    ex_reg(8'h89, 8'h07);
  endtask
  task automatic t_host_read();
    wr_reg(8'h89, 8'h17);
    wr_reg(8'h08, 8'ha5);
    ex_reg(8'h89, 8'h57);
    wr_reg(8'h88, 8'h00);
    #1;
    `CHK(data_oe_n, 8'hff)
    `CHK(ctrl_oe_n, 3'h7)
    wr_reg(8'h88, 8'hff);
    i_host.access(1'b0, 8'h00, hb);
    `CHK(hb, 8'ha5)
    ex_reg(8'h89, 8'h17);
    ex_reg(8'h0c, 8'h80);
    `CHK(irq, 1'b0)
    wr_reg(8'h8c, 8'h80);
    ex_reg(8'h8c, 8'h80);
    `CHK(irq, 1'b1)
    wr_reg(8'h0c, 8'h00);
    ex_reg(8'h0c, 8'h00);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_host_write();
    i_host.access(1'b1, 8'h3c, hb);
    ex_reg(8'h89, 8'h97);
    ex_reg(8'h0c, 8'h80);
    `CHK(irq, 1'b1)
    ex_reg(8'h08, 8'h3c);
    ex_reg(8'h89, 8'h17);
    i_host.access(1'b1, 8'h11, hb);
    wr_reg(8'h89, 8'h17);
    ex_reg(8'h89, 8'h97);
    i_host.access(1'b1, 8'h22, hb);
    ex_reg(8'h89, 8'hb7);
  endtask
  task automatic t_mode_off();
    wr_reg(8'h89, 8'h27);
    ex_reg(8'h89, 8'h27);
    wr_reg(8'h0c, 8'h00);
    i_host.access(1'b1, 8'h55, hb);
    ex_reg(8'h0c, 8'h00);
    wr_reg(8'h89, 8'h07);
    ex_reg(8'h89, 8'h07);
    wr_reg(8'h89, 8'h03);
    wr_reg(8'h88, 8'h0f);
    wr_reg(8'h09, 8'h05);
    #1;
    `CHK(ctrl_oe_n, 3'h3)
    `CHK(data_oe_n, 8'h0f)
    `CHK(ctrl_out, 3'h5)
  endtask
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_host_read();
    t_host_write();
    t_mode_off();
    close_out();
  end
endmodule
